// ### rtl/tpswd_pkg.sv
/*
 * Shared constants and types for the timer with the divider that is shared
 * with the watchdog.
 * Assumes a single 50 MHz system clock, where one clock is one oscillator
 * period and four clocks make one instruction cycle.
 */
package tpswd_pkg;

    // ====================================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int DRT_TIME_US = 18000;
    localparam int DRT_CYCLES = (DRT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WDT_STEPS = 256;
    localparam int WDT_TICK_CYCLES = DRT_CYCLES / WDT_STEPS;

    // ====================================================================
    // Instruction cycle phases
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] PH_STEP = 2'h1;
    localparam logic [1:0] INHIBIT_CYC = 2'h2;

    // ====================================================================
    // Register map and reset values
    localparam logic [4:0] TIMER_ADDR = 5'h01;
    localparam logic [7:0] OPT_RESET = 8'hff;
    localparam logic [5:0] DIR_RESET = 6'h3f;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] CNT_FULL = 8'hff;

    // Write-only configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic wake_dis;
        logic pullup_dis;
        logic clk_src;
        logic edge_sel;
        logic assign_wdt;
        logic [2:0] ratio;
    } tpswd_opt_s;

    // Oscillator modes
    typedef enum logic [2:0] {
        OSC_LP, OSC_XT, OSC_INTERNAL_OSC_MODE, OSC_EXTERNAL_RESISTOR_CAP_OSC, OSC_HS
    } tpswd_osc_e;

endpackage

// ### rtl/tpswd_core.sv
/*
 * Timer/counter with an 8-bit divider shared with the watchdog, plus the
 * device reset timer and the sleep wake logic.
 * Assumes the core issues one-cycle instruction strobes on clk_sys and that
 * the pin inputs are asynchronous to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module tpswd_core import tpswd_pkg::*; #(
    parameter int DRT_CYC = DRT_CYCLES,
    parameter int WDT_TICK_CYC = WDT_TICK_CYCLES,
    parameter int TIMER_PIN_BIT = 2,
    parameter bit LARGE_PKG = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // File register write port
    input wire logic f_wr,
    input wire logic [4:0] f_addr,
    input wire logic [7:0] f_wdata,
    // Special instruction strobes
    input wire logic opt_wr,
    input wire logic dir_wr_small,
    input wire logic dir_wr_large,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    // Pins and fuses
    input wire logic timer_ext_clock_pin,
    input wire logic [5:0] port_pins,
    input wire logic watchdog_enable_fuse,
    input wire tpswd_osc_e osc_mode,
    input wire logic power_up,
    // Status and results
    output logic [7:0] timer_count_value,
    output logic [5:0] pin_dir_eff,
    output logic wdt_timeout,
    output logic wake_event,
    output logic sleeping,
    output logic chip_reset_hold
);

    localparam int DRT_W = $clog2(DRT_CYC + 1);
    localparam int WT_W = $clog2(WDT_TICK_CYC + 1);
    localparam logic [DRT_W-1:0] DRT_LOAD = DRT_W'(DRT_CYC);
    localparam logic [WT_W-1:0] WT_LAST = WT_W'(WDT_TICK_CYC - 1);

    // ====================================================================
    // State
    logic [1:0] qph, next_qph;
    logic ext_s1, ext_s2;
    logic [5:0] gp_s1, gp_s2;
    logic pin_prev, next_pin_prev;
    tpswd_opt_s cfg, next_cfg;
    logic [5:0] pin_direction_small_pkg, next_dir_small;
    logic [5:0] pin_direction_large_pkg, next_dir_large;
    logic [7:0] div, next_div;
    logic pre_smp, next_pre_smp;
    logic smp_rise, next_smp_rise;
    logic [7:0] next_tmr;
    logic [1:0] inhibit, next_inhibit;
    logic [WT_W-1:0] wdt_osc, next_wdt_osc;
    logic [7:0] wdt_cnt, next_wdt_cnt;
    logic [DRT_W-1:0] drt_cnt, next_drt_cnt;
    logic drt_arm;
    logic [5:0] gp_snap, next_gp_snap;
    logic [5:0] next_pin_dir;
    logic next_wdt_timeout, next_wake_event, next_sleeping, next_hold;

    // Working terms
    logic pin_eff, ext_rise, is_q4, smp_now, src_tick, pre_lvl, inc;
    logic tmr_hit, wdt_tick, wdt_ovf, wdt_fire, xtal, pin_chg;
    logic [7:0] post_mask;

    // ====================================================================
    // Pin synchronisers, nothing else reads the first stage
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            gp_s1 <= 6'h00;
            gp_s2 <= 6'h00;
        end else begin
            ext_s1 <= timer_ext_clock_pin;
            ext_s2 <= ext_s1;
            gp_s1 <= port_pins;
            gp_s2 <= gp_s1;
        end
    end

    // ====================================================================
    // Next-state logic
    always_comb begin
        // Edge select inverts the pin so a rising level always counts
        pin_eff = ext_s2 ^ cfg.edge_sel;
        ext_rise = pin_eff & ~pin_prev;
        is_q4 = (qph == PH_Q4);
        smp_now = (qph == PH_Q2) || is_q4;
        src_tick = cfg.clk_src ? ext_rise : is_q4;
        // Divider output, or the raw pin when the divider is elsewhere
        pre_lvl = !cfg.assign_wdt ? div[cfg.ratio] : pin_eff;
        // Undivided internal clock counts once per instruction cycle
        inc = (!cfg.clk_src && cfg.assign_wdt) ? is_q4 : smp_rise;
        tmr_hit = f_wr && (f_addr == TIMER_ADDR);
        wdt_tick = (wdt_osc == WT_LAST);
        wdt_ovf = watchdog_enable_fuse && wdt_tick && (wdt_cnt == CNT_FULL);
        post_mask = ~(CNT_FULL << cfg.ratio);
        wdt_fire = wdt_ovf && (!cfg.assign_wdt || ((div & post_mask) == post_mask));
        xtal = (osc_mode == OSC_LP) || (osc_mode == OSC_XT) || (osc_mode == OSC_HS);
        pin_chg = !cfg.wake_dis && (gp_s2 != gp_snap);

        next_qph = qph + PH_STEP;
        next_pin_prev = pin_eff;
        next_pre_smp = smp_now ? pre_lvl : pre_smp;
        next_smp_rise = smp_now && pre_lvl && !pre_smp;

        // Configuration and direction registers, write-only
        next_cfg = opt_wr ? tpswd_opt_s'(f_wdata) : cfg;
        next_dir_small = dir_wr_small ? f_wdata[5:0] : pin_direction_small_pkg;
        next_dir_large = dir_wr_large ? f_wdata[5:0] : pin_direction_large_pkg;
        next_pin_dir = LARGE_PKG ? pin_direction_large_pkg : pin_direction_small_pkg;
        next_pin_dir[TIMER_PIN_BIT] = next_pin_dir[TIMER_PIN_BIT] | cfg.clk_src;

        // Shared divider, one user at a time; clears beat increments
        next_div = div;
        if (!cfg.assign_wdt && src_tick) begin
            next_div = div + 8'h01;
        end else if (cfg.assign_wdt && wdt_ovf) begin
            next_div = div + 8'h01;
        end
        if (tmr_hit && !cfg.assign_wdt) begin
            next_div = DIV_RESET;
        end
        if (watchdog_clear_instr && cfg.assign_wdt) begin
            next_div = DIV_RESET;
        end

        // Timer count with a short hold-off after every write
        next_tmr = timer_count_value;
        next_inhibit = inhibit;
        if (tmr_hit) begin
            next_tmr = f_wdata;
            next_inhibit = INHIBIT_CYC;
        end else begin
            if (is_q4 && inhibit != 2'h0) begin
                next_inhibit = inhibit - 2'h1;
            end
            if (inhibit == 2'h0 && inc) begin
                next_tmr = timer_count_value + 8'h01;
            end
        end

        // Watchdog on its own tick; the fuse is its only off switch
        next_wdt_osc = wdt_tick ? '0 : wdt_osc + WT_W'(1);
        next_wdt_cnt = wdt_cnt;
        if (watchdog_clear_instr) begin
            next_wdt_cnt = 8'h00;
        end else if (watchdog_enable_fuse && wdt_tick) begin
            next_wdt_cnt = wdt_cnt + 8'h01;
        end
        next_wdt_timeout = wdt_fire;

        // Sleep entry and wake
        next_sleeping = sleeping;
        next_gp_snap = gp_snap;
        next_wake_event = 1'b0;
        if (sleep_instr && !sleeping) begin
            next_sleeping = 1'b1;
            next_gp_snap = gp_s2;
        end else if (sleeping && (pin_chg || wdt_fire)) begin
            next_sleeping = 1'b0;
            next_wake_event = 1'b1;
        end

        // Reset timer; power-up level is caught on the first cycle out
        next_drt_cnt = (drt_cnt != '0) ? drt_cnt - DRT_W'(1) : drt_cnt;
        if (drt_arm && (xtal || power_up)) begin
            next_drt_cnt = DRT_LOAD;
        end else if (wdt_fire && xtal) begin
            next_drt_cnt = DRT_LOAD;
        end
        next_hold = (next_drt_cnt != '0);
    end

    // ====================================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            qph <= PH_Q1;
            pin_prev <= 1'b0;
            cfg <= tpswd_opt_s'(OPT_RESET);
            pin_direction_small_pkg <= DIR_RESET;
            pin_direction_large_pkg <= DIR_RESET;
            div <= DIV_RESET;
            pre_smp <= 1'b0;
            smp_rise <= 1'b0;
            timer_count_value <= 8'h00;
            inhibit <= 2'h0;
            wdt_osc <= '0;
            wdt_cnt <= 8'h00;
            wdt_timeout <= 1'b0;
            sleeping <= 1'b0;
            gp_snap <= 6'h00;
            wake_event <= 1'b0;
            drt_cnt <= '0;
            drt_arm <= 1'b1;
            chip_reset_hold <= 1'b1;
            pin_dir_eff <= DIR_RESET;
        end else begin
            qph <= next_qph;
            pin_prev <= next_pin_prev;
            cfg <= next_cfg;
            pin_direction_small_pkg <= next_dir_small;
            pin_direction_large_pkg <= next_dir_large;
            div <= next_div;
            pre_smp <= next_pre_smp;
            smp_rise <= next_smp_rise;
            timer_count_value <= next_tmr;
            inhibit <= next_inhibit;
            wdt_osc <= next_wdt_osc;
            wdt_cnt <= next_wdt_cnt;
            wdt_timeout <= next_wdt_timeout;
            sleeping <= next_sleeping;
            gp_snap <= next_gp_snap;
            wake_event <= next_wake_event;
            drt_cnt <= next_drt_cnt;
            drt_arm <= 1'b0;
            chip_reset_hold <= next_hold;
            pin_dir_eff <= next_pin_dir;
        end
    end

    // ====================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    smp_phase_a: assert property ($changed(pre_smp) |-> $past(smp_now))
        else $error("divider output sampled outside Q2 and Q4");
    tmr_clr_a: assert property ((tmr_hit && !cfg.assign_wdt) |=> div == DIV_RESET)
        else $error("timer write did not clear the divider");
    wdt_clr_a: assert property ((watchdog_clear_instr && cfg.assign_wdt)
        |=> (div == DIV_RESET && wdt_cnt == 8'h00))
        else $error("watchdog clear missed divider or counter");
    div_excl_a: assert property ((cfg.assign_wdt && !wdt_ovf && !watchdog_clear_instr)
        |=> $stable(div))
        else $error("divider moved while owned by the watchdog");
    div_reset_a: assert property ($rose(reset_n) |-> div == DIV_RESET)
        else $error("divider not zero after reset");
    inhibit_hold_a: assert property ((tmr_hit ##1 !tmr_hit [*4])
        |-> timer_count_value == $past(f_wdata, 4))
        else $error("timer counted during the write hold-off");
    pin_dir_a: assert property (cfg.clk_src |=> pin_dir_eff[TIMER_PIN_BIT])
        else $error("timer pin not forced to input");
    // The arm term catches the hold that starts straight out of reset
    drt_hold_a: assert property (($rose(chip_reset_hold)
        || (drt_arm && (xtal || power_up))) |=> chip_reset_hold [*8])
        else $error("reset timer hold ended early");
    wake_wdt_a: assert property ((sleeping && wdt_fire) |=> (wake_event && !sleeping))
        else $error("watchdog time-out did not wake");
    wake_pin_a: assert property ((sleeping && pin_chg) |=> (wake_event && !sleeping))
        else $error("pin change did not wake");
    wdt_fuse_a: assert property ((!watchdog_enable_fuse && !watchdog_clear_instr)
        |=> $stable(wdt_cnt))
        else $error("watchdog counted with the fuse off");
    // Source must be the pin on both edges, else an internal count slips in
    inc_sync_a: assert property ((cfg.clk_src && $past(cfg.clk_src)
        && inhibit == 2'h0 && !tmr_hit && !$past(tmr_hit)
        && timer_count_value != $past(timer_count_value))
        |-> $past(smp_rise))
        else $error("external count without a sampled edge");

    ext_count_c: cover property (cfg.clk_src && smp_rise && inhibit == 2'h0);
    drt_load_c: cover property (drt_arm && xtal);
    wdt_fire_c: cover property (wdt_fire && cfg.assign_wdt);
    wake_pin_c: cover property (sleeping && pin_chg);

endmodule

`default_nettype wire

// ### tb/tpswd_clk_src.sv
/*
 * Far-side model: an external clock source on the timer clock pin.
 * Assumes the bench calls send() from its own process; the pin idles low.
 */
`timescale 1ns/1ns
`default_nettype none

module tpswd_clk_src (
    // Reference clock for pulse widths
    input wire logic clk_sys,
    // Timer clock pin
    output logic pin
);
    // ====================================================================
    // Pulse train
    initial pin = 1'b0;

    // Widths are clamped to two periods so a caller cannot go below spec
    task automatic send(input int n, input int hi, input int lo);
        int h;
        int l;
        h = (hi < 2) ? 2 : hi;
        l = (lo < 2) ? 2 : lo;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            pin = 1'b1;
            repeat (h) @(negedge clk_sys);
            pin = 1'b0;
            repeat (l - 1) @(negedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench for the timer with the shared divider.
 * Assumes tpswd_core with short reset-timer and watchdog-tick parameters.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench import tpswd_pkg::*;;
    logic clk_sys, reset_n, f_wr, opt_wr, dir_wr_small, wclr, sleep_instr;
    logic fuse, power_up, wdt_timeout, wake_event, sleeping, chip_reset_hold;
    logic [4:0] f_addr;
    logic [7:0] f_wdata, timer_count_value, v;
    logic [5:0] port_pins, pin_dir_eff;
    tpswd_osc_e osc_mode;
    wire logic ext_pin;
    int n_mismatch = 0, total_checks = 0, n_to = 0, n_wk = 0;

    tpswd_clk_src tpswd_clk_src_inst (.clk_sys(clk_sys), .pin(ext_pin));
    tpswd_core #(.DRT_CYC(20), .WDT_TICK_CYC(4)) tpswd_core_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .f_wr(f_wr), .f_addr(f_addr),
        .f_wdata(f_wdata), .opt_wr(opt_wr), .dir_wr_small(dir_wr_small),
        .dir_wr_large(1'b0), .watchdog_clear_instr(wclr),
        .sleep_instr(sleep_instr), .timer_ext_clock_pin(ext_pin),
        .port_pins(port_pins), .watchdog_enable_fuse(fuse), .osc_mode(osc_mode),
        .power_up(power_up), .timer_count_value(timer_count_value),
        .pin_dir_eff(pin_dir_eff), .wdt_timeout(wdt_timeout),
        .wake_event(wake_event), .sleeping(sleeping),
        .chip_reset_hold(chip_reset_hold));

    // ====================================================================
    // Clock, pulse monitors and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // One-cycle pulses are counted mid-cycle, where they stand settled
    always @(negedge clk_sys) begin
        if (wdt_timeout === 1'b1) n_to++;
        if (wake_event === 1'b1) n_wk++;
    end

    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end

    // ====================================================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Kinds: 0 timer write, 1 config, 2 direction, 3 wdt clear, 4 sleep, 5 bad addr
    task automatic strobe(input int k, input logic [7:0] d);
        @(negedge clk_sys);
        f_wdata = d;
        f_addr = (k == 5) ? 5'h02 : TIMER_ADDR;
        f_wr = (k == 0 || k == 5);
        opt_wr = (k == 1);
        dir_wr_small = (k == 2);
        wclr = (k == 3);
        sleep_instr = (k == 4);
        @(negedge clk_sys);
        {f_wr, opt_wr, dir_wr_small, wclr, sleep_instr} = 5'h00;
    endtask

    task automatic do_reset(input tpswd_osc_e m, input logic pu);
        osc_mode = m;
        power_up = pu;
        reset_n = 1'b0;
        wt(10);
        chk("timer rst", 8'h00, timer_count_value);
        chk("dir rst", {2'h0, DIR_RESET}, {2'h0, pin_dir_eff});
        reset_n = 1'b1;
    endtask

    // ====================================================================
    // Scenarios
    task automatic t_drt();
        do_reset(OSC_XT, 1'b0);
        wt(10);
        chk("hold xt", 8'h01, {7'h0, chip_reset_hold});
        wt(20);
        chk("hold end", 8'h00, {7'h0, chip_reset_hold});
        do_reset(OSC_EXTERNAL_RESISTOR_CAP_OSC, 1'b1);
        wt(3);
        chk("hold pu", 8'h01, {7'h0, chip_reset_hold});
        do_reset(OSC_INTERNAL_OSC_MODE, 1'b0);
        wt(3);
        chk("hold rc", 8'h00, {7'h0, chip_reset_hold});
        $display("test drt done");
    endtask

    // Ten increments must take exactly ten periods of the chosen rate
    task automatic t_rates();
        for (int r = -1; r < 3; r++) begin
            strobe(3, 8'h00);
            strobe(1, (r < 0) ? 8'h08 : 8'(r));
            strobe(0, 8'h00);
            wt(40);
            v = timer_count_value;
            wt((r < 0) ? 40 : 80 << r);
            chk("rate", v + 8'h0a, timer_count_value);
        end
        $display("test rates done");
    endtask

    task automatic t_write();
        strobe(1, 8'h28);
        strobe(0, 8'h55);
        strobe(5, 8'haa);
        chk("bad addr", 8'h55, timer_count_value);
        strobe(1, 8'h08);
        strobe(0, 8'h3c);
        chk("write", 8'h3c, timer_count_value);
        // Without the hold-off a Q4 would already have counted by now
        wt(6);
        chk("inhibit", 8'h3c, timer_count_value);
        $display("test write done");
    endtask

    // Pin rising, pin falling, then pin through the 1:2 divider
    task automatic t_pin();
        logic [7:0] cf[3] = '{8'h28, 8'h38, 8'h20};
        logic [7:0] ex[3] = '{8'h0a, 8'h0a, 8'h05};
        for (int i = 0; i < 3; i++) begin
            strobe(1, cf[i]);
            strobe(0, 8'h00);
            wt(10);
            tpswd_clk_src_inst.send(10, 2, 2);
            wt(12);
            chk("pin count", ex[i], timer_count_value);
        end
        $display("test pin done");
    endtask

    task automatic t_dir();
        strobe(2, 8'h00);
        strobe(1, 8'h28);
        wt(2);
        chk("dir pin", 8'h04, {2'h0, pin_dir_eff});
        strobe(1, 8'h08);
        wt(2);
        chk("dir free", 8'h00, {2'h0, pin_dir_eff});
        $display("test dir done");
    endtask

    task automatic t_wdt();
        strobe(1, 8'h00);
        strobe(3, 8'h00);
        n_to = 0;
        wt(900);
        strobe(3, 8'h00);
        wt(900);
        chk("wdt early", 8'h00, 8'(n_to));
        wt(300);
        chk("wdt fire", 8'h01, 8'(n_to));
        strobe(3, 8'h00);
        strobe(0, 8'h00);
        strobe(1, 8'h09);
        strobe(3, 8'h00);
        wt(1500);
        strobe(3, 8'h00);
        n_to = 0;
        wt(1900);
        chk("wdt div clr", 8'h00, 8'(n_to));
        wt(300);
        chk("wdt div fire", 8'h01, 8'(n_to));
        fuse = 1'b0;
        strobe(3, 8'h00);
        n_to = 0;
        wt(2500);
        chk("wdt off", 8'h00, 8'(n_to));
        fuse = 1'b1;
        $display("test wdt done");
    endtask

    task automatic t_sleep();
        strobe(3, 8'h00);
        strobe(1, 8'h00);
        n_wk = 0;
        strobe(4, 8'h00);
        wt(3);
        chk("asleep", 8'h01, {7'h0, sleeping});
        wt(1100);
        chk("wdt wake", 8'h01, 8'(n_wk));
        strobe(3, 8'h00);
        strobe(4, 8'h00);
        wt(5);
        port_pins = 6'h3e;
        wt(10);
        chk("pin wake", 8'h02, 8'(n_wk));
        chk("awake", 8'h00, {7'h0, sleeping});
        $display("test sleep done");
    endtask

    // ====================================================================
    // Main sequence
    initial begin
        {f_wr, opt_wr, dir_wr_small, wclr, sleep_instr} = 5'h00;
        f_addr = 5'h00;
        f_wdata = 8'h00;
        port_pins = 6'h3f;
        fuse = 1'b1;
        t_drt();
        t_rates();
        t_write();
        t_pin();
        t_dir();
        t_wdt();
        t_sleep();
        stop_test();
    end
endmodule
`default_nettype wire
